// ### hw/ddlk_defines.vh
// Log keeper constants: APB map, sector layout, reset values, timing.
// Assumes 9-bit byte indexes and 8-bit log addresses.
`ifndef DDLK_DEFINES_VH
`define DDLK_DEFINES_VH

`define DDLK_CLK_HZ 25000000
`define DDLK_MS_PER_S 1000
`define DDLK_MS_CYCLES (`DDLK_CLK_HZ / `DDLK_MS_PER_S)

`define DDLK_A_CTRL 12'h000
`define DDLK_A_INDEX 12'h004
`define DDLK_A_DATA 12'h008
`define DDLK_A_STATUS 12'h00c

`define DDLK_LA_DIR 8'h00
`define DDLK_LA_ERR 8'h01
`define DDLK_LA_ST 8'h06
`define DDLK_LA_SEL 8'h09
`define DDLK_LA_HOST_LO 8'h80
`define DDLK_LA_HOST_HI 8'h9f
`define DDLK_HOST_SECTORS 8'h10

`define DDLK_LOG_VERSION 8'h01
`define DDLK_ERR_VERSION 8'h01
`define DDLK_ST_REVISION 8'h01
`define DDLK_SEL_REVISION 8'h01

`define DDLK_LAST_BYTE 9'd511
`define DDLK_SUM_LAST 9'd510
`define DDLK_REC_BASE 9'd2
`define DDLK_REC_BYTES 90
`define DDLK_REC_END 9'd451
`define DDLK_CMD_BYTES 60
`define DDLK_ERRCNT_LO 9'd452
`define DDLK_ERRCNT_HI 9'd453
`define DDLK_ERR_RECS 3'd5
`define DDLK_ST_DESC_BYTES 24
`define DDLK_ST_FIELD_BYTES 9
`define DDLK_ST_END 9'd505
`define DDLK_ST_PTR_BYTE 9'd508
`define DDLK_ST_DESCS 5'd21
`define DDLK_SEL_SPAN_END 9'd81
`define DDLK_SEL_CUR_LBA 9'd492
`define DDLK_SEL_CUR_SPAN 9'd500
`define DDLK_SEL_FLAGS 9'd502
`define DDLK_SEL_PEND 9'd508

`endif

// ### hw/ddlk_log_keeper.v
// Diagnostic log keeper: directory, error log, self-test log and selective self-test log,
// served byte by byte over an APB slave.
// Assumes event strobes from the command front end on the same clock.
// Functional notes
// RULE1: Log address zero serves the directory as one 512-byte sector.
// RULE2: Directory bytes 0-1 version; even byte 2k counts sectors of log k; odd reserved.
// RULE3: Directory logging version word reads 01h.
// RULE4: Logs at 80h-9Fh are reported and treated as 16 sectors long. Here they are only reported as 16 sectors; their bytes read zero.
// RULE5: Error log: version, pointer, five 90-byte records, count at 452-453, checksum 511.
// RULE6: Error log version byte reads 01h.
// RULE7: Error pointer names the newest record and only takes values 1 to 5.
// RULE8: Sixteen-bit error count saturates, never wraps to zero.
// RULE9: A record is five 12-byte command snapshots then a 30-byte error snapshot.
// RULE10: Command snapshot keeps task-file bytes at command write, command at offset 7.
// RULE11: Snapshot offsets 8-11 hold power-on milliseconds at acceptance, wrapping allowed.
// RULE12: Error snapshot offsets 1-7 hold completion registers; offset 0 reserved.
// RULE13: Extended error bytes 8-26 carry no content and read zero.
// RULE14: Offset 27 low nibble holds the device state code at command issue.
// RULE15: Offsets 28-29 hold the lifetime timestamp, low byte first.
// RULE16: Self-test log: revision word, 24-byte descriptors at 24n+2 for n 0-20.
// RULE17: After 21 descriptors each new one overwrites the oldest, as a ring.
// RULE18: Self-test pointer at 508 reads 0 when empty, else newest descriptor 1-21.
// RULE19: Host reads and writes five test spans; device updates current LBA and span.
// RULE20: Host-written feature flags and pending time are kept and read back unchanged.
// RULE21: Byte 511 is the two's complement of the byte sum of bytes 0-510.
// RULE22: Multi-byte fields are stored least significant byte first.
// RULE23: A new error advances the pointer cyclically 5 to 1 and overwrites that record.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "ddlk_defines.vh"
module ddlk_log_keeper #(
  parameter MS_CYCLES = `DDLK_MS_CYCLES
) (
  input wire clock,              // device clock, 25 MHz
  input wire rst_n,              // async reset, active low
  input wire clk_en,             // freezes all state while low
  input wire psel,               // APB select
  input wire penable,            // APB access phase
  input wire pwrite,             // APB direction, high for write
  input wire [11:0] paddr,       // APB byte address
  input wire [31:0] pwdata,      // APB write data
  output wire pready,            // APB ready
  output reg [31:0] prdata,      // APB read data
  output reg pslverr,            // APB error for unmapped address
  input wire cmd_stb,            // command register written, one-cycle pulse
  input wire [7:0] tf_devctl,    // device control at command write
  input wire [7:0] tf_feat,      // features at command write
  input wire [7:0] tf_count,     // sector count at command write
  input wire [7:0] tf_lba_lo,    // LBA low at command write
  input wire [7:0] tf_lba_mid,   // LBA mid at command write
  input wire [7:0] tf_lba_hi,    // LBA high at command write
  input wire [7:0] tf_dev,       // device/head at command write
  input wire [7:0] tf_cmd,       // command code
  input wire [3:0] dev_state,    // device state code at command issue
  input wire err_stb,            // command completed with error, one-cycle pulse
  input wire [7:0] cp_error,     // error register at completion
  input wire [7:0] cp_count,     // sector count at completion
  input wire [7:0] cp_lba_lo,    // LBA low at completion
  input wire [7:0] cp_lba_mid,   // LBA mid at completion
  input wire [7:0] cp_lba_hi,    // LBA high at completion
  input wire [7:0] cp_dev,       // device/head at completion
  input wire [7:0] cp_status,    // status at completion
  input wire [15:0] life_ts,     // lifetime timestamp
  input wire st_stb,             // self-test finished, one-cycle pulse
  input wire [7:0] st_num,       // self-test number
  input wire [7:0] st_status,    // self-test execution status
  input wire [7:0] st_ckpt,      // failure checkpoint
  input wire [31:0] st_lba,      // LBA of first failure
  input wire sel_prog_stb,       // selective test progress update, one-cycle pulse
  input wire [63:0] sel_cur_lba, // current LBA under test
  input wire [15:0] sel_cur_span // current span under test
);
  reg [7:0] logsel_r;
  reg [8:0] idx_r;
  reg [15:0] ms_div_r;
  reg [31:0] ms_r;
  reg [95:0] hist_r [0:4];
  reg [3:0] hist_st_r [0:4];
  reg [479:0] rec_cmd_r [0:4];
  reg [239:0] rec_err_r [0:4];
  reg [2:0] err_ptr_r;
  reg [15:0] err_cnt_r;
  reg [71:0] st_r [0:20];
  reg [4:0] st_ptr_r;
  reg [7:0] sel_rev_r [0:1];
  reg [127:0] span_r [0:4];
  reg [63:0] cur_lba_r;
  reg [15:0] cur_span_r;
  reg [15:0] flags_r;
  reg [15:0] pend_r;
  reg dirty_r;
  reg busy_r;
  reg [8:0] walk_r;
  reg [7:0] csum_r;
  wire [7:0] sum_out;
  wire [2:0] err_ptr_nxt;
  wire [4:0] st_ptr_nxt;
  wire [8:0] wofs;
  wire setup;
  wire acc;
  wire data_hit;
  wire host_wr;
  integer i;

  // One decoder serves the bus and the checksum walk.
  function [7:0] get_byte;
    input [7:0] ls;
    input [8:0] ix;
    integer r;
    integer o;
    begin
      get_byte = 8'h00;
      r = 0;
      o = 0;
      if (ix == `DDLK_LAST_BYTE) begin
        get_byte = csum_r; // RULE21
      end else if (ls == `DDLK_LA_DIR) begin // RULE1
        if (ix == 9'd0) begin
          get_byte = `DDLK_LOG_VERSION; // RULE3
        end else if (!ix[0] && ix != 9'd0) begin // RULE2
          if (ix[8:1] == `DDLK_LA_ERR || ix[8:1] == `DDLK_LA_ST ||
              ix[8:1] == `DDLK_LA_SEL) begin
            get_byte = 8'h01;
          end else if (ix[8:1] >= `DDLK_LA_HOST_LO && ix[8:1] <= `DDLK_LA_HOST_HI) begin
            // Host logs report their size but hold no data here.
            get_byte = `DDLK_HOST_SECTORS; // RULE4
          end
        end
      end else if (ls == `DDLK_LA_ERR) begin // RULE5
        if (ix == 9'd0) begin
          get_byte = `DDLK_ERR_VERSION; // RULE6
        end else if (ix == 9'd1) begin
          get_byte = {5'h00, err_ptr_r};
        end else if (ix <= `DDLK_REC_END) begin // RULE9
          r = (ix - 2) / `DDLK_REC_BYTES;
          o = (ix - 2) % `DDLK_REC_BYTES;
          if (o < `DDLK_CMD_BYTES) begin
            get_byte = rec_cmd_r[r][8*o +: 8];
          end else begin
            get_byte = rec_err_r[r][8*(o-`DDLK_CMD_BYTES) +: 8];
          end
        end else if (ix == `DDLK_ERRCNT_LO) begin
          get_byte = err_cnt_r[7:0]; // RULE22
        end else if (ix == `DDLK_ERRCNT_HI) begin
          get_byte = err_cnt_r[15:8];
        end
      end else if (ls == `DDLK_LA_ST) begin // RULE16
        if (ix == 9'd0) begin
          get_byte = `DDLK_ST_REVISION;
        end else if (ix >= `DDLK_REC_BASE && ix <= `DDLK_ST_END) begin
          r = (ix - 2) / `DDLK_ST_DESC_BYTES;
          o = (ix - 2) % `DDLK_ST_DESC_BYTES;
          if (o < `DDLK_ST_FIELD_BYTES) begin
            get_byte = st_r[r][8*o +: 8];
          end
        end else if (ix == `DDLK_ST_PTR_BYTE) begin
          get_byte = {3'h0, st_ptr_r}; // RULE18
        end
      end else if (ls == `DDLK_LA_SEL) begin // RULE19
        if (ix <= 9'd1) begin
          get_byte = sel_rev_r[ix[0]];
        end else if (ix <= `DDLK_SEL_SPAN_END) begin
          r = (ix - 2) / 16;
          o = (ix - 2) % 16;
          get_byte = span_r[r][8*o +: 8];
        end else if (ix >= `DDLK_SEL_CUR_LBA && ix < `DDLK_SEL_CUR_SPAN) begin
          get_byte = cur_lba_r[8*(ix-`DDLK_SEL_CUR_LBA) +: 8];
        end else if (ix[8:1] == `DDLK_SEL_CUR_SPAN >> 1) begin
          get_byte = cur_span_r[8*ix[0] +: 8];
        end else if (ix[8:1] == `DDLK_SEL_FLAGS >> 1) begin
          get_byte = flags_r[8*ix[0] +: 8]; // RULE20
        end else if (ix[8:1] == `DDLK_SEL_PEND >> 1) begin
          get_byte = pend_r[8*ix[0] +: 8];
        end
      end
    end
  endfunction

  assign setup = psel && !penable;
  assign acc = psel && penable && clk_en;
  assign pready = clk_en;
  assign data_hit = paddr == `DDLK_A_DATA;
  assign host_wr = acc && pwrite && data_hit && logsel_r == `DDLK_LA_SEL;
  assign wofs = idx_r - 9'd2;
  assign err_ptr_nxt = (err_ptr_r == `DDLK_ERR_RECS) ? 3'd1 :
                       err_ptr_r + 3'd1; // RULE23
  assign st_ptr_nxt = (st_ptr_r == `DDLK_ST_DESCS) ? 5'd1 : st_ptr_r + 5'd1; // RULE17

  // Read data is captured in setup so it leaves a flip-flop in the access phase.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      logsel_r <= 8'h00;
      idx_r <= 9'h000;
    end else if (clk_en) begin
      if (setup) begin
        pslverr <= !(paddr == `DDLK_A_CTRL || paddr == `DDLK_A_INDEX ||
                     data_hit || paddr == `DDLK_A_STATUS);
        case (paddr)
          `DDLK_A_CTRL: prdata <= {24'h000000, logsel_r};
          `DDLK_A_INDEX: prdata <= {23'h000000, idx_r};
          `DDLK_A_DATA: prdata <= {24'h000000, get_byte(logsel_r, idx_r)};
          `DDLK_A_STATUS: prdata <= {err_cnt_r, 3'h0, st_ptr_r, 4'h0, err_ptr_r, busy_r};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (acc && pwrite && paddr == `DDLK_A_CTRL) begin
        logsel_r <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == `DDLK_A_INDEX) begin
        idx_r <= pwdata[8:0];
      end else if (acc && data_hit) begin
        idx_r <= idx_r + 9'd1;
      end
    end
  end

  // Millisecond counter since power-on; it simply wraps.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_r <= 16'h0000;
      ms_r <= 32'h00000000;
    end else if (clk_en) begin
      if (ms_div_r == MS_CYCLES[15:0] - 16'd1) begin
        ms_div_r <= 16'h0000;
        ms_r <= ms_r + 32'd1; // RULE11
      end else begin
        ms_div_r <= ms_div_r + 16'd1;
      end
    end
  end

  // Command history, oldest in slot 0, and the error records built from it.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 5; i = i + 1) begin
        hist_r[i] <= 96'h0;
        hist_st_r[i] <= 4'h0;
        rec_cmd_r[i] <= 480'h0;
        rec_err_r[i] <= 240'h0;
      end
      err_ptr_r <= `DDLK_ERR_RECS;
      err_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      if (err_stb) begin
        err_ptr_r <= err_ptr_nxt; // RULE7
        rec_cmd_r[err_ptr_nxt - 3'd1] <=
          {hist_r[4], hist_r[3], hist_r[2], hist_r[1], hist_r[0]};
        rec_err_r[err_ptr_nxt - 3'd1] <= {life_ts, 4'h0, hist_st_r[4], 152'h0, // RULE12 RULE13
                                          cp_status, cp_dev, cp_lba_hi, cp_lba_mid, cp_lba_lo,
                                          cp_count, cp_error, 8'h00}; // RULE14 RULE15
        if (err_cnt_r != 16'hffff) begin
          err_cnt_r <= err_cnt_r + 16'd1; // RULE8
        end
      end
      if (cmd_stb) begin
        for (i = 0; i < 4; i = i + 1) begin
          hist_r[i] <= hist_r[i + 1];
          hist_st_r[i] <= hist_st_r[i + 1];
        end
        hist_r[4] <= {ms_r, tf_cmd, tf_dev, tf_lba_hi, tf_lba_mid, // RULE10 RULE22
                      tf_lba_lo, tf_count, tf_feat, tf_devctl};
        hist_st_r[4] <= dev_state;
      end
    end
  end

  // Self-test ring and the selective log.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 21; i = i + 1) begin
        st_r[i] <= 72'h0;
      end
      for (i = 0; i < 5; i = i + 1) begin
        span_r[i] <= 128'h0;
      end
      st_ptr_r <= 5'd0;
      sel_rev_r[0] <= `DDLK_SEL_REVISION;
      sel_rev_r[1] <= 8'h00;
      cur_lba_r <= 64'h0;
      cur_span_r <= 16'h0000;
      flags_r <= 16'h0000;
      pend_r <= 16'h0000;
    end else if (clk_en) begin
      if (st_stb) begin
        st_ptr_r <= st_ptr_nxt;
        st_r[st_ptr_nxt - 5'd1] <=
          {st_lba, st_ckpt, life_ts, st_status, st_num}; // RULE16
      end
      if (sel_prog_stb) begin
        cur_lba_r <= sel_cur_lba; // RULE19
        cur_span_r <= sel_cur_span;
      end
      if (host_wr) begin
        if (idx_r <= 9'd1) begin
          sel_rev_r[idx_r[0]] <= pwdata[7:0];
        end else if (idx_r <= `DDLK_SEL_SPAN_END) begin
          span_r[wofs[6:4]][8*wofs[3:0] +: 8] <= pwdata[7:0]; // RULE19
        end else if (idx_r[8:1] == `DDLK_SEL_FLAGS >> 1) begin
          flags_r[8*idx_r[0] +: 8] <= pwdata[7:0]; // RULE20
        end else if (idx_r[8:1] == `DDLK_SEL_PEND >> 1) begin
          pend_r[8*idx_r[0] +: 8] <= pwdata[7:0]; // RULE20
        end
      end
    end
  end

  // Checksum walk: any change to the selected sector restarts a 511-cycle scan. A byte 511 read
  // during the scan returns the previous value, so software waits for the busy bit to fall.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dirty_r <= 1'b1;
      busy_r <= 1'b0;
      walk_r <= 9'h000;
      csum_r <= 8'h00;
    end else if (clk_en) begin
      dirty_r <= cmd_stb || err_stb || st_stb || sel_prog_stb || host_wr ||
                 (acc && pwrite && paddr == `DDLK_A_CTRL);
      if (dirty_r) begin
        busy_r <= 1'b1;
        walk_r <= 9'h000;
      end else if (busy_r) begin
        walk_r <= walk_r + 9'd1;
        if (walk_r == `DDLK_SUM_LAST) begin
          busy_r <= 1'b0;
          csum_r <= sum_out - get_byte(logsel_r, walk_r); // RULE21
        end
      end
    end
  end

  ddlk_sum8 u_sum (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .clr(dirty_r),
    .add_en(busy_r),
    .din(get_byte(logsel_r, walk_r)),
    .csum(sum_out)
  );
endmodule

// ### hw/ddlk_sum8.v
// Running 8-bit byte sum used to produce a sector checksum.
// Assumes a clear before the first byte and one byte per enabled cycle.
`timescale 1ns/1ns
module ddlk_sum8 (
  input wire clock,         // device clock
  input wire rst_n,         // async reset, active low
  input wire clk_en,        // freezes the sum while low
  input wire clr,           // restart the sum at zero
  input wire add_en,        // add din this cycle
  input wire [7:0] din,     // byte to add
  output wire [7:0] csum    // two's complement of the sum so far
);
  reg [7:0] acc_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 8'h00;
    end else if (clk_en) begin
      if (clr) begin
        acc_r <= 8'h00;
      end else if (add_en) begin
        acc_r <= acc_r + din;
      end
    end
  end

  assign csum = 8'h00 - acc_r; // RULE21
endmodule

// ### tb/ddlk_apb_host.sv
// Host-side APB master model, one transfer at a time.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ns
module ddlk_apb_host (
  input wire clock, // device clock
  input wire pready, // slave ready
  input wire [31:0] prdata, // slave read data
  input wire pslverr, // slave error
  output reg psel, // select
  output reg penable, // access phase
  output reg pwrite, // direction
  output reg [11:0] paddr, // byte address
  output reg [31:0] pwdata, // write data
  output reg hung // last transfer saw no ready
);
  initial begin
    {psel, penable, pwrite, hung, paddr, pwdata} = 48'h0;
  end
  task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q, output e);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (!pready && n < 32) begin
        n = n + 1;
        @(posedge clock);
      end
      hung = !pready;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show the inverse, so a stale request cannot pass.
      pwrite <= ~w;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clock);
    end
  endtask
endmodule

// ### tb/ddlk_log_keeper_bench.sv
// Self-checking bench for the log keeper: sectors, events, APB map.
// Assumes the host model drives APB; the bench drives the strobes.
`timescale 1ns/1ns
`include "ddlk_defines.vh"
module ddlk_log_keeper_bench;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg clk_en = 1'b1;
  reg cmd_stb = 1'b0, err_stb = 1'b0, st_stb = 1'b0, sel_prog_stb = 1'b0;
  reg [3:0] dev_state = 4'h0;
  reg [7:0] st_num = 8'h00, st_status = 8'h00, st_ckpt = 8'h00;
  reg [15:0] life_ts = 16'h0000, sel_cur_span = 16'h0000;
  reg [31:0] st_lba = 32'h0;
  reg [63:0] sel_cur_lba = 64'h0;
  reg [7:0] tf [0:7];
  reg [7:0] cp [0:7];
  reg [7:0] sec [0:511];
  reg [31:0] q;
  reg e;
  integer err_count = 0, tests_run = 0, i;
  wire pready, pslverr, psel, penable, pwrite;
  wire [31:0] prdata, pwdata;
  wire [11:0] paddr;
  always #20 clock = ~clock;
  ddlk_log_keeper #(.MS_CYCLES(10)) dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmd_stb(cmd_stb),
    .tf_devctl(tf[0]), .tf_feat(tf[1]), .tf_count(tf[2]), .tf_lba_lo(tf[3]),
    .tf_lba_mid(tf[4]), .tf_lba_hi(tf[5]), .tf_dev(tf[6]), .tf_cmd(tf[7]),
    .dev_state(dev_state), .err_stb(err_stb), .cp_error(cp[1]), .cp_count(cp[2]),
    .cp_lba_lo(cp[3]), .cp_lba_mid(cp[4]), .cp_lba_hi(cp[5]), .cp_dev(cp[6]),
    .cp_status(cp[7]), .life_ts(life_ts), .st_stb(st_stb), .st_num(st_num),
    .st_status(st_status), .st_ckpt(st_ckpt), .st_lba(st_lba), .sel_prog_stb(sel_prog_stb),
    .sel_cur_lba(sel_cur_lba), .sel_cur_span(sel_cur_span));
  ddlk_apb_host host_u (.clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung());
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      err_count = err_count + 1;
      $display("BAD %0t wait ran out", $time);
      close_out;
    end
  endtask
  task cmp_word(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cmp_byte(input [7:0] got, input [7:0] exp);
    cmp_word({24'h0, got}, {24'h0, exp});
  endtask
  task bus(input [11:0] a, input w, input [31:0] d);
    begin
      host_u.xfer(a, w, d, q, e);
      if (host_u.hung)
        hang;
    end
  endtask
  // Mask bits: 0 cmd, 1 error, 2 self-test, 3 progress.
  task strobe(input [3:0] m);
    begin
      {sel_prog_stb, st_stb, err_stb, cmd_stb} <= m;
      @(posedge clock);
      {sel_prog_stb, st_stb, err_stb, cmd_stb} <= 4'h0;
      @(posedge clock);
    end
  endtask
  // A CTRL write restarts the checksum scan, so wait for it.
  task dump(input [7:0] la);
    integer n;
    reg [7:0] s;
    begin
      bus(`DDLK_A_CTRL, 1'b1, {24'h0, la});
      q = 32'h1;
      for (n = 0; n < 400 && q[0] !== 1'b0; n = n + 1)
        bus(`DDLK_A_STATUS, 1'b0, 32'h0);
      if (q[0] !== 1'b0)
        hang;
      bus(`DDLK_A_INDEX, 1'b1, 32'h0);
      s = 8'h00;
      for (n = 0; n < 512; n = n + 1) begin
        bus(`DDLK_A_DATA, 1'b0, 32'h0);
        sec[n] = q[7:0];
        s = s + q[7:0];
      end
      cmp_byte(s, 8'h00);
    end
  endtask
  task t_dir;
    integer k;
    begin
      bus(`DDLK_A_STATUS, 1'b0, 32'h0);
      cmp_word(q & 32'hffff1f0e, 32'h0000000a);
      dump(`DDLK_LA_DIR);
      cmp_byte(sec[0], `DDLK_LOG_VERSION);
      cmp_byte(sec[1], 8'h00);
      for (k = 1; k < 256; k = k + 1) begin
        cmp_byte(sec[2 * k], (k == 1 || k == 6 || k == 9) ? 8'h01 :
          (k >= 128 && k <= 159) ? 8'h10 : 8'h00);
        if (k < 255)
          cmp_byte(sec[2 * k + 1], 8'h00);
      end
      $display("directory done");
    end
  endtask
  task t_err1;
    integer j;
    reg [31:0] t0, t1;
    begin
      for (j = 1; j < 6; j = j + 1) begin
        for (i = 0; i < 8; i = i + 1)
          tf[i] <= {j[3:0], i[3:0]};
        dev_state <= j[3:0] - 4'h1;
        strobe(4'h1);
        repeat (98) @(posedge clock);
      end
      for (i = 1; i < 8; i = i + 1)
        cp[i] <= {4'ha, i[3:0]};
      life_ts <= 16'hbe01;
      strobe(4'h2);
      dump(`DDLK_LA_ERR);
      cmp_byte(sec[0], `DDLK_ERR_VERSION);
      cmp_byte(sec[1], 8'h01);
      cmp_word({sec[453], sec[452]}, 32'h1);
      for (j = 0; j < 5; j = j + 1) begin
        for (i = 0; i < 8; i = i + 1)
          cmp_byte(sec[2 + 12 * j + i], {j[3:0] + 4'h1, i[3:0]});
        t1 = {sec[13 + 12 * j], sec[12 + 12 * j], sec[11 + 12 * j], sec[10 + 12 * j]};
        if (j > 0)
          cmp_word(t1 - t0, 32'd10);
        t0 = t1;
      end
      for (i = 0; i < 8; i = i + 1)
        cmp_byte(sec[62 + i], i == 0 ? 8'h00 : {4'ha, i[3:0]});
      for (i = 70; i < 89; i = i + 1)
        cmp_byte(sec[i], 8'h00);
      cmp_byte(sec[89] & 8'h0f, 8'h04);
      cmp_word({sec[91], sec[90]}, 32'hbe01);
      for (i = 92; i < 511; i = i + 1)
        if (i < 452 || i > 453)
          cmp_byte(sec[i], 8'h00);
      $display("error log done");
    end
  endtask
  task t_err2;
    integer k;
    begin
      for (k = 2; k < 7; k = k + 1) begin
        dev_state <= k[3:0] % 4'h5;
        strobe(4'h1);
        cp[1] <= k[7:0];
        strobe(4'h2);
        bus(`DDLK_A_STATUS, 1'b0, 32'h0);
        cmp_word(q & 32'hffff000e, {k[15:0], 12'h000, k[2:0] == 3'h6 ? 3'h1 : k[2:0], 1'b0});
      end
      dump(`DDLK_LA_ERR);
      cmp_byte(sec[1], 8'h01);
      for (i = 1; i < 6; i = i + 1) begin
        k = (i == 1) ? 6 : i;
        cmp_byte(sec[90 * i - 27], k[7:0]);
        cmp_byte(sec[90 * i - 1] & 8'h0f, k[7:0] % 8'h05);
      end
      // A strobe held high counts one error per cycle.
      err_stb <= 1'b1;
      repeat (65530) @(posedge clock);
      err_stb <= 1'b0;
      @(posedge clock);
      fork
        bus(`DDLK_A_STATUS, 1'b0, 32'h0);
        begin
          @(posedge clock);
          clk_en <= 1'b0;
          repeat (3) @(posedge clock);
          clk_en <= 1'b1;
        end
      join
      cmp_word(q & 32'hffff000e, 32'hffff0002);
      $display("error wrap done");
    end
  endtask
  task t_st;
    integer k, b;
    begin
      dump(`DDLK_LA_ST);
      cmp_word({sec[1], sec[0], sec[508]}, {16'h0, `DDLK_ST_REVISION, 8'h00});
      for (k = 1; k < 24; k = k + 1) begin
        st_num <= k[7:0];
        st_status <= ~k[7:0];
        st_ckpt <= k[7:0] + 8'h80;
        st_lba <= {8'hc0, 16'h0, k[7:0]};
        life_ts <= {8'h70, k[7:0]};
        strobe(4'h4);
        bus(`DDLK_A_STATUS, 1'b0, 32'h0);
        b = (k - 1) % 21 + 1;
        cmp_word(q & 32'h00001f00, {19'h0, b[4:0], 8'h00});
      end
      dump(`DDLK_LA_ST);
      cmp_byte(sec[508], 8'h02);
      for (i = 0; i < 21; i = i + 1) begin
        k = (i < 2) ? i + 22 : i + 1;
        b = 24 * i + 2;
        cmp_word({sec[b], sec[b + 1], sec[b + 3], sec[b + 2]}, {k[7:0], ~k[7:0], 8'h70, k[7:0]});
        cmp_word({sec[b + 8], sec[b + 7], sec[b + 6], sec[b + 5]}, {8'hc0, 16'h0, k[7:0]});
        cmp_byte(sec[b + 4], k[7:0] + 8'h80);
      end
      $display("self-test done");
    end
  endtask
  task t_sel;
    reg [7:0] x;
    begin
      sel_cur_lba <= 64'h0807060504030201;
      sel_cur_span <= 16'h0003;
      strobe(4'h8);
      bus(`DDLK_A_CTRL, 1'b1, 32'h9);
      bus(`DDLK_A_INDEX, 1'b1, 32'h2);
      for (i = 2; i < 84; i = i + 1)
        bus(`DDLK_A_DATA, 1'b1, {24'h0, i[7:0] ^ 8'h5a});
      bus(`DDLK_A_INDEX, 1'b1, 32'd492);
      for (i = 492; i < 511; i = i + 1)
        bus(`DDLK_A_DATA, 1'b1, {24'h0, i[7:0] ^ 8'h5a});
      dump(`DDLK_LA_SEL);
      cmp_byte(sec[0], `DDLK_SEL_REVISION);
      for (i = 1; i < 511; i = i + 1) begin
        x = ((i > 1 && i < 82) || i == 502 || i == 503 || i == 508 || i == 509) ?
          i[7:0] ^ 8'h5a : 8'h00;
        if (i >= 492 && i < 500)
          x = i[7:0] - 8'heb;
        if (i == 500)
          x = 8'h03;
        if (i < 504 || i > 507)
          cmp_byte(sec[i], x);
      end
      $display("selective done");
    end
  endtask
  task t_apb;
    begin
      bus(12'h010, 1'b0, 32'h0);
      cmp_word({q[31:1], q[0] | ~e}, 32'h0);
      bus(`DDLK_A_CTRL, 1'b0, 32'h0);
      cmp_word(q, 32'h9);
      bus(`DDLK_A_INDEX, 1'b0, 32'h0);
      cmp_word(q, 32'h0);
      $display("map done");
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      tf[i] = 8'h00;
      cp[i] = 8'h00;
    end
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_dir;
    t_err1;
    t_err2;
    t_st;
    t_sel;
    t_apb;
    close_out;
  end
  initial begin
    repeat (95000) @(posedge clock);
    hang;
  end
endmodule
bind ddlk_log_keeper ddlk_log_keeper_monitor mon_u (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr));

// ### tb/ddlk_log_keeper_monitor.sv
// Checker for the keeper's APB port and status word.
// Assumes it is bound into the keeper and sees only its ports.
`timescale 1ns/1ns
`include "ddlk_defines.vh"
module ddlk_log_keeper_monitor (
  input wire clock, // device clock
  input wire rst_n, // async reset, active low
  input wire clk_en, // clock enable
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB address
  input wire pready, // APB ready
  input wire [31:0] prdata, // APB read data
  input wire pslverr // APB error
);
  reg [15:0] cnt_seen_r;
  wire done = psel && penable && pready;
  wire st_rd = done && !pwrite && paddr == `DDLK_A_STATUS;
  wire mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // Count at the last status read, so that a wrap is caught.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      cnt_seen_r <= 16'h0000;
    else if (st_rd)
      cnt_seen_r <= prdata[31:16];
  end
  a_ready_tracks_en: assert property (pready == clk_en)
    else $error("ready differs from enable");
  a_unmapped_refused: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_clean: assert property (done && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_data_byte_only: assert property (done && !pwrite && paddr == `DDLK_A_DATA |->
    prdata[31:8] == 24'h0) else $error("data upper bits set");
  a_errptr_legal: assert property (st_rd |-> prdata[3:1] >= 3'd1 && prdata[3:1] <= 3'd5)
    else $error("error pointer bad");
  a_stptr_legal: assert property (st_rd |-> prdata[12:8] <= 5'd21)
    else $error("self-test pointer bad");
  a_count_no_wrap: assert property (st_rd |-> prdata[31:16] >= cnt_seen_r)
    else $error("error count went down");
  a_reply_holds: assert property (s_setup ##1 s_done |=> $stable(prdata) && $stable(pslverr))
    else $error("reply changed");
endmodule
